// ==== spectral_cmd_pkg.sv ====
// Constants and types shared by the measurement-control command decoder
package spectral_cmd_pkg;

  // ----------------------------------------------------------------------
  // Characters
  // ----------------------------------------------------------------------
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_T     = 8'h54;
  localparam logic [7:0] CH_EQ    = 8'h3d;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_X     = 8'h58;
  localparam logic [7:0] CH_XL    = 8'h78;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_O     = 8'h4f;
  localparam logic [7:0] CH_K     = 8'h4b;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_R     = 8'h52;

  // ----------------------------------------------------------------------
  // Command names after the two-letter prefix, right aligned
  // ----------------------------------------------------------------------
  localparam logic [55:0] NM_TIME   = "INTTIME";
  localparam logic [55:0] NM_GAIN   = {24'h000000, "GAIN"};
  localparam logic [55:0] NM_INTRP  = {16'h0000, "INTRP"};
  localparam logic [55:0] NM_MODE   = {16'h0000, "TCSMD"};
  localparam logic [55:0] NM_INTRVL = {8'h00, "INTRVL"};
  localparam logic [55:0] NM_BURST  = {16'h0000, "BURST"};
  localparam logic [47:0] NM_LED    = {24'h000000, "LED"};

  // ----------------------------------------------------------------------
  // Values after reset, the unlimited burst count and the reserved LED current bits
  // ----------------------------------------------------------------------
  localparam logic [7:0] INT_TIME_RST  = 8'h14;
  localparam logic [1:0] GAIN_RST      = 2'h1;
  localparam logic       IRQ_EN_RST    = 1'h0;
  localparam logic [1:0] CAP_MODE_RST  = 2'h2;
  localparam logic [7:0] INTERVAL_RST  = 8'h01;
  localparam logic [7:0] BURST_RST     = 8'h00;
  localparam logic [7:0] BURST_FOREVER = 8'hff;
  localparam logic [5:0] LED_EN_RST    = 6'h15;
  localparam logic [7:0] LEDC_RST      = 8'h00;
  localparam logic [7:0] LEDC_RSV_MASK = 8'hcc;

  // ----------------------------------------------------------------------
  // Timing and response buffer sizes
  // ----------------------------------------------------------------------
  localparam real INT_UNIT_MS = 2.8;
  localparam int  CLK_MHZ     = 50;
  localparam int  UNIT_CYCLES = int'(INT_UNIT_MS * 1000.0 * CLK_MHZ);
  localparam int  RESP_MAX    = 10;
  localparam int  FIFO_DEPTH  = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [1:0] driver_current_field;
    logic [1:0] rsv_lo;
    logic [1:0] indicator_current_field;
  } led_current_t;

  typedef struct packed {
    logic [7:0]   int_time;
    logic [1:0]   gain;
    logic         irq_en;
    logic [1:0]   cap_mode;
    logic [7:0]   interval;
    logic [7:0]   burst_cnt;
    logic         burst_cal;
    logic [5:0]   led_en;
    led_current_t led_cur;
  } settings_t;

  typedef struct packed {
    logic [1:0]  n;
    logic [23:0] s;
  } dec_t;

endpackage

// ==== resp_fifo.sv ====
// Shift-register FIFO carrying response bytes toward the transmitter
`timescale 1ns/1ns
module resp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt != CW'(D));
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[0];
  assign next_cnt    = cnt + CW'(push) - CW'(pop);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt         <= '0;
      out_valid_o <= 1'b0;
    end
    else
    begin
      cnt         <= next_cnt;
      out_valid_o <= (next_cnt != '0);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    for (int i = 0; i < D; i++)
    begin
      if (pop)
      begin
        if (push && (CW'(i) == cnt - CW'(1)))
          mem[i] <= in_data_i;
        else if (i < D - 1)
          mem[i] <= mem[(i < D - 1) ? i + 1 : i];
      end
      else if (push && (CW'(i) == cnt))
        mem[i] <= in_data_i;
    end
  end
endmodule

// ==== spectral_control_command_set.sv ====
// Text command decoder and settings store for the measurement-control group
`timescale 1ns/1ns

// Operation
// [R1] Integration time 1..255, default 20, unit 2.8 ms.
// [R2] Gain code 0..3: 1x, 3.7x, 16x, 64x; default 1.
// [R3] Interrupt pin enable 0/1; off after reset.
// [R4] Mode 0 bank 0, mode 1 bank 1, one period each.
// [R5] Mode 2 (default) both banks continuous; mode 3 once.
// [R6] Sample every N integration times, N 1..255, default 1.
// [R7] Burst mode sends results unrequested.
// [R8] Burst 0 stops (default); 1..254 sends that many.
// [R9] Burst 255 streams until 0 is written.
// [R10] Second burst argument: 0 raw (default), 1 calibrated.
// [R11] Burst read returns count, mode, then OK.
// [R12] Six LED enables; indicators on, drivers off at reset.
// [R13] LED current: bits 1:0 indicator, 5:4 driver; reset 0.
// [R14] Query returns value; argument stores it.
// [R15] Decimal numbers, or hex after 0x.
// [R16] CR, LF or both end commands; replies end CR LF.
// [R17] Failures answer ERROR.
// [R18] Successful writes answer OK.
module spectral_control_command_set
  import spectral_cmd_pkg::*;
#(
  parameter int UNIT_CYC = UNIT_CYCLES
) (
  input  wire logic  core_clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  output logic       rx_ready_o,
  output logic       tx_valid_o,
  output logic [7:0] tx_data_o,
  input  wire logic  tx_ready_i,
  output settings_t  settings_o,
  output logic       sample_o,
  output logic       bank_o,
  output logic       burst_req_o
);
  typedef enum {S_LINE, S_EXEC, S_SEND} state_t;
  typedef enum {C_NOP, C_TIME, C_GAIN, C_INTRP, C_MODE, C_INTRVL,
                C_BURST, C_LED, C_LEDC, C_BAD} cmd_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction

  function automatic logic [7:0] hexchr(input logic [3:0] v);
    return (v < 4'ha) ? CH_0 + 8'(v) : CH_A + 8'(v - 4'ha);
  endfunction

  function automatic dec_t dec3(input logic [7:0] v);
    dec_t d;
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    h = v / 8'h64;
    t = (v / 8'h0a) % 8'h0a;
    o = v % 8'h0a;
    d.n = (v >= 8'h64) ? 2'h3 : (v >= 8'h0a) ? 2'h2 : 2'h1;
    if (d.n == 2'h3)
      d.s = {CH_0 + h, CH_0 + t, CH_0 + o};
    else if (d.n == 2'h2)
      d.s = {CH_0 + t, CH_0 + o, 8'h00};
    else
      d.s = {CH_0 + o, 16'h0000};
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // Line collection
  // ----------------------------------------------------------------------
  state_t      state;
  logic        err, has_eq, argi, hex, dok, take, fifo_ready;
  logic [3:0]  pos, dval, rlen, sidx;
  logic [55:0] name;
  logic [2:0]  nlen;
  logic [1:0]  dig;
  logic [8:0]  acc, arg0;
  logic [7:0]  ch;
  logic [12:0] next_acc;

  assign take = rx_valid_i && rx_ready_o;
  assign ch   = upcase(rx_data_i);

  // [R15] decimal or hex digit
  always_comb
  begin
    dok  = 1'b0;
    dval = 4'h0;
    if (ch >= CH_0 && ch <= 8'h39)
    begin
      dok  = 1'b1;
      dval = 4'(ch - CH_0);
    end
    else if (hex && ch >= CH_A && ch <= 8'h46)
    begin
      dok  = 1'b1;
      dval = 4'(ch - CH_A + 8'h0a);
    end
    next_acc = hex ? {acc, 4'h0} + 13'(dval) : 13'(acc) * 13'h00a + 13'(dval);
  end

  // Reset, or reply fully queued: back to an empty line
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || (state == S_SEND && fifo_ready && sidx == rlen - 4'h1))
    begin
      state      <= S_LINE;
      rx_ready_o <= 1'b1;
      pos        <= '0;
      err        <= 1'b0;
      has_eq     <= 1'b0;
      name       <= '0;
      nlen       <= '0;
      argi       <= 1'b0;
      hex        <= 1'b0;
      dig        <= '0;
      acc        <= '0;
      arg0       <= '0;
    end
    else
    begin
      case (state)
        S_LINE:
        begin
          if (take)
          begin
            // [R16] either terminator ends the line
            if (ch == CH_CR || ch == CH_LF)
            begin
              if (pos != '0)
              begin
                state      <= S_EXEC;
                rx_ready_o <= 1'b0;
              end
            end
            else
            begin
              pos <= (pos == 4'hf) ? pos : pos + 4'h1;
              if (pos == 4'h0)
                err <= err | (ch != CH_A);
              else if (pos == 4'h1)
                err <= err | (ch != CH_T);
              else if (!has_eq)
              begin
                if (ch == CH_EQ)
                  has_eq <= 1'b1;
                else if (nlen == 3'h7)
                  err <= 1'b1;
                else
                begin
                  name <= {name[47:0], ch};
                  nlen <= nlen + 3'h1;
                end
              end
              else if (ch == CH_COMMA)
              begin
                err  <= err | argi | (dig == '0);
                argi <= 1'b1;
                arg0 <= acc;
                acc  <= '0;
                hex  <= 1'b0;
                dig  <= '0;
              end
              // [R15] leading 0x switches to hex
              else if (ch == CH_X && !hex && dig == 2'h1 && acc == '0)
              begin
                hex <= 1'b1;
                dig <= '0;
              end
              else if (dok)
              begin
                acc <= (next_acc > 13'h0ff) ? 9'h100 : 9'(next_acc);
                dig <= (dig == 2'h3) ? dig : dig + 2'h1;
              end
              else
                err <= 1'b1;
            end
          end
        end
        S_EXEC:
          state <= S_SEND;
        S_SEND:
          state <= S_SEND;
        default:
          state <= S_LINE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Decode and check
  // ----------------------------------------------------------------------
  cmd_t       cmd;
  logic       rd, ok;
  logic [8:0] a0, a1;
  logic [2:0] led_i;
  logic [7:0] v0, v1;

  always_comb
  begin
    led_i = 3'(name[2:0]);
    if (nlen == '0)
      cmd = C_NOP;
    else if (name == NM_TIME)
      cmd = C_TIME;
    else if (name == NM_GAIN)
      cmd = C_GAIN;
    else if (name == NM_INTRP)
      cmd = C_INTRP;
    else if (name == NM_MODE)
      cmd = C_MODE;
    else if (name == NM_INTRVL)
      cmd = C_INTRVL;
    else if (name == NM_BURST)
      cmd = C_BURST;
    else if (name[55:8] == NM_LED && name[7:0] == CH_E - 8'h02)
      cmd = C_LEDC;
    else if (name[55:8] == NM_LED && name[7:0] >= CH_0 && name[7:0] <= 8'h35)
      cmd = C_LED;
    else
      cmd = C_BAD;
    rd = !has_eq;
    a0 = argi ? arg0 : acc;
    // [R10] omitted burst mode means raw
    a1 = argi ? acc : 9'h000;
    // [R17] syntax, argument count and range failures
    ok = !err && cmd != C_BAD && !(has_eq && (dig == '0 || cmd == C_NOP));
    if (argi && cmd != C_BURST)
      ok = 1'b0;
    if (has_eq)
    begin
      case (cmd)
        // [R1] integration time range
        C_TIME:   ok = ok && a0 >= 9'h001 && a0 <= 9'h0ff;
        // [R2] gain code range
        C_GAIN:   ok = ok && a0 <= 9'h003;
        // [R3] pin enable range
        C_INTRP:  ok = ok && a0 <= 9'h001;
        C_MODE:   ok = ok && a0 <= 9'h003;
        // [R6] interval range
        C_INTRVL: ok = ok && a0 >= 9'h001 && a0 <= 9'h0ff;
        C_BURST:  ok = ok && a0 <= 9'h0ff && a1 <= 9'h001;
        C_LED:    ok = ok && a0 <= 9'h001;
        C_LEDC:   ok = ok && a0 <= 9'h0ff && (a0[7:0] & LEDC_RSV_MASK) == 8'h00;
        default:  ok = ok;
      endcase
    end
    // [R14] query returns stored value
    case (cmd)
      C_TIME:   v0 = settings_o.int_time;
      C_GAIN:   v0 = 8'(settings_o.gain);
      C_INTRP:  v0 = 8'(settings_o.irq_en);
      C_MODE:   v0 = 8'(settings_o.cap_mode);
      C_INTRVL: v0 = settings_o.interval;
      C_BURST:  v0 = settings_o.burst_cnt;
      C_LED:    v0 = 8'(settings_o.led_en[led_i]);
      C_LEDC:   v0 = settings_o.led_cur;
      default:  v0 = 8'h00;
    endcase
    v1 = 8'(settings_o.burst_cal);
  end

  // ----------------------------------------------------------------------
  // Response assembly
  // ----------------------------------------------------------------------
  logic [7:0] resp [RESP_MAX];
  logic [7:0] rbuf [RESP_MAX];
  logic [3:0] next_rlen;
  dec_t       d0, d1;

  always_comb
  begin
    int k;
    k  = 0;
    d0 = dec3(v0);
    d1 = dec3(v1);
    for (int j = 0; j < RESP_MAX; j++)
      resp[j] = 8'h00;
    if (ok && rd && cmd != C_NOP)
    begin
      if (cmd == C_LEDC)
      begin
        resp[0] = CH_0;
        resp[1] = CH_XL;
        resp[2] = hexchr(v0[7:4]);
        resp[3] = hexchr(v0[3:0]);
        k = 4;
      end
      else
      begin
        for (int j = 0; j < 3; j++)
          if (j < int'(d0.n))
          begin
            resp[k] = d0.s[23 - 8 * j -: 8];
            k = k + 1;
          end
        // [R11] count, comma, mode
        if (cmd == C_BURST)
        begin
          resp[k] = CH_COMMA;
          k = k + 1;
          resp[k] = d1.s[23:16];
          k = k + 1;
        end
      end
    end
    // [R18] acknowledge success
    if (ok)
    begin
      resp[k] = CH_O;
      resp[k + 1] = CH_K;
      k = k + 2;
    end
    // [R17] error reply
    else
    begin
      resp[k] = CH_E;
      resp[k + 1] = CH_R;
      resp[k + 2] = CH_R;
      resp[k + 3] = CH_O;
      resp[k + 4] = CH_R;
      k = k + 5;
    end
    // [R16] reply terminator
    resp[k] = CH_CR;
    resp[k + 1] = CH_LF;
    next_rlen = 4'(k + 2);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      rlen <= 4'h1;
      sidx <= '0;
    end
    else if (state == S_EXEC)
    begin
      rlen <= next_rlen;
      sidx <= '0;
      for (int j = 0; j < RESP_MAX; j++)
        rbuf[j] <= resp[j];
    end
    else if (state == S_SEND && fifo_ready)
      sidx <= sidx + 4'h1;
  end

  resp_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (state == S_SEND),
    .in_data_i   (rbuf[sidx]),
    .in_ready_o  (fifo_ready),
    .out_valid_o (tx_valid_o),
    .out_data_o  (tx_data_o),
    .out_ready_i (tx_ready_i)
  );

  // ----------------------------------------------------------------------
  // Settings store
  // ----------------------------------------------------------------------
  logic wr;
  assign wr = (state == S_EXEC) && ok && !rd;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      // [R12] [R13] indicators on, drivers off, currents zero
      settings_o <= {INT_TIME_RST, GAIN_RST, IRQ_EN_RST, CAP_MODE_RST, INTERVAL_RST,
                     BURST_RST, 1'b0, LED_EN_RST, LEDC_RST};
    end
    else if (wr)
    begin
      case (cmd)
        C_TIME:   settings_o.int_time <= a0[7:0];
        C_GAIN:   settings_o.gain <= a0[1:0];
        C_INTRP:  settings_o.irq_en <= a0[0];
        C_MODE:   settings_o.cap_mode <= a0[1:0];
        C_INTRVL: settings_o.interval <= a0[7:0];
        C_BURST:
        begin
          settings_o.burst_cnt <= a0[7:0];
          settings_o.burst_cal <= a1[0];
        end
        // [R12] per-LED enable
        C_LED:    settings_o.led_en[led_i] <= a0[0];
        // [R13] indicator and driver current fields
        C_LEDC:   settings_o.led_cur <= a0[7:0];
        default:  ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Measurement timing and burst streaming
  // ----------------------------------------------------------------------
  logic [17:0] unit_cnt;
  logic [7:0]  int_cnt, per_cnt, target, burst_left;
  logic        running, restart, period_end;

  assign restart    = wr && (cmd == C_TIME || cmd == C_MODE || cmd == C_INTRVL);
  assign period_end = running && unit_cnt == 18'(UNIT_CYC - 1)
                      && int_cnt == settings_o.int_time - 8'h01;
  // [R5] two periods when both banks are captured at interval 1
  assign target     = (settings_o.cap_mode[1] && settings_o.interval == 8'h01)
                      ? 8'h02 : settings_o.interval;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || restart)
    begin
      unit_cnt <= '0;
      int_cnt  <= '0;
      per_cnt  <= '0;
      running  <= 1'b1;
      sample_o <= 1'b0;
      // [R4] single-bank modes fix the bank
      bank_o   <= !rst_n_i ? 1'b0 : (a0[1:0] == 2'h1 && cmd == C_MODE) ||
                  (cmd != C_MODE && settings_o.cap_mode == 2'h1);
    end
    else
    begin
      sample_o <= 1'b0;
      if (running)
      begin
        // [R1] units of the integration step
        unit_cnt <= (unit_cnt == 18'(UNIT_CYC - 1)) ? '0 : unit_cnt + 18'h1;
        if (unit_cnt == 18'(UNIT_CYC - 1))
          int_cnt <= (int_cnt == settings_o.int_time - 8'h01) ? '0 : int_cnt + 8'h01;
      end
      if (period_end)
      begin
        if (settings_o.cap_mode[1])
          bank_o <= !bank_o;
        // [R6] one sample per N integration times
        if (per_cnt == target - 8'h01)
        begin
          per_cnt  <= '0;
          sample_o <= 1'b1;
          // [R5] one-shot stops after its sample
          if (settings_o.cap_mode == 2'h3)
            running <= 1'b0;
        end
        else
          per_cnt <= per_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      burst_left  <= BURST_RST;
      burst_req_o <= 1'b0;
    end
    // [R8] new count restarts or stops the stream
    else if (wr && cmd == C_BURST)
    begin
      burst_left  <= a0[7:0];
      burst_req_o <= 1'b0;
    end
    else
    begin
      // [R7] send each result unrequested
      burst_req_o <= sample_o && burst_left != 8'h00;
      // [R9] unlimited count never decrements
      if (sample_o && burst_left != 8'h00 && burst_left != BURST_FOREVER)
        burst_left <= burst_left - 8'h01;
    end
  end
endmodule

// ==== spectral_control_command_set_asserts.sv ====
// Port assertions for the command decoder
`timescale 1ns/1ns
module spectral_control_command_set_asserts
  import spectral_cmd_pkg::*;
#(
  parameter int UNIT_CYC = 2
) (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic       rx_ready_o,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_ready_i,
  input wire settings_t  settings_o,
  input wire logic       sample_o,
  input wire logic       bank_o,
  input wire logic       burst_req_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic        line_has;
  logic        armed;
  logic [17:0] key_q;
  int          cyc;
  int          tgt;
  int          per;
  wire logic [17:0] key = {settings_o.int_time, settings_o.cap_mode, settings_o.interval};
  wire logic        take = rx_valid_i && rx_ready_o;
  wire logic        term = rx_data_i == CH_CR || rx_data_i == CH_LF;
  wire logic        two = settings_o.cap_mode[1] && settings_o.interval == 8'h01;
  assign tgt = two ? 2 : int'(settings_o.interval);
  assign per = int'(settings_o.int_time) * tgt * UNIT_CYC;
  always_ff @(posedge core_clk_i)
  begin
    key_q    <= key;
    line_has <= rst_n_i && (take ? !term : line_has);
  end
  // Cycles since last sample
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || key != key_q)
    begin
      armed <= 1'b0;
      cyc   <= 0;
    end
    else if (sample_o)
    begin
      armed <= 1'b1;
      cyc   <= 1;
    end
    else
      cyc <= cyc + 1;
  end
  property p_defaults;
    $rose(rst_n_i) |-> settings_o == {8'h14, 2'h1, 1'h0, 2'h2, 8'h01, 8'h00, 1'h0,
      6'h15, 8'h00};
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("settings not at reset values");
  property p_ranges;
    settings_o.int_time != 8'h00 && settings_o.interval != 8'h00
      && (settings_o.led_cur & LEDC_RSV_MASK) == 8'h00;
  endproperty
  a_ranges: assert property (p_ranges)
    else $error("setting outside its range");
  property p_reply;
    take && term && line_has |=> !rx_ready_o ##[0:8] tx_valid_o;
  endproperty
  a_reply: assert property (p_reply)
    else $error("no reply after line end");
  property p_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("reply byte dropped while stalled");
  property p_period;
    sample_o && armed |-> cyc == per;
  endproperty
  a_period: assert property (p_period)
    else $error("sample spacing wrong");
  property p_follow;
    burst_req_o |-> $past(sample_o) && !$past(burst_req_o);
  endproperty
  a_follow: assert property (p_follow)
    else $error("burst request without sample");
  property p_forever;
    sample_o && settings_o.burst_cnt == BURST_FOREVER |=> burst_req_o;
  endproperty
  a_forever: assert property (p_forever)
    else $error("unlimited burst missed");
  property p_zero;
    settings_o.burst_cnt == 8'h00 && $past(settings_o.burst_cnt) == 8'h00 |-> !burst_req_o;
  endproperty
  a_zero: assert property (p_zero)
    else $error("burst while stopped");
  property p_bank;
    !settings_o.cap_mode[1] && $stable(settings_o.cap_mode)
      && $past(settings_o.cap_mode, 2) == settings_o.cap_mode
      |-> bank_o == settings_o.cap_mode[0];
  endproperty
  a_bank: assert property (p_bank)
    else $error("wrong bank in single bank mode");
endmodule

bind spectral_control_command_set spectral_control_command_set_asserts #(
  .UNIT_CYC(UNIT_CYC)
) chk (
  .core_clk_i, .rst_n_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o,
  .tx_data_o, .tx_ready_i, .settings_o, .sample_o, .bank_o, .burst_req_o
);

// ==== spectral_host_model.sv ====
// Host model: sends command lines and gathers the text replies
`timescale 1ns/1ns
module spectral_host_model (
  input  wire logic       core_clk_i,
  input  wire logic       cmd_ready_i,
  input  wire logic       rsp_valid_i,
  input  wire logic [7:0] rsp_data_i,
  input  wire logic       stall_i,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_data_o,
  output logic            rsp_ready_o
);
  string rsp;
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_data_o  = 8'h00;
    rsp_ready_o = 1'b1;
  end
  always @(negedge core_clk_i)
  begin
    rsp_ready_o = !stall_i;
    if (rsp_valid_i && rsp_ready_o)
      rsp = {rsp, string'(rsp_data_i)};
  end
  // prefix, arguments and chosen line end
  task automatic send(input string s, input string term, output string r);
    string line;
    int    n;
    line = {"AT", s, term};
    rsp  = "";
    n    = 0;
    foreach (line[i])
    begin
      @(negedge core_clk_i);
      cmd_valid_o = 1'b1;
      cmd_data_o  = line[i];
      while (!cmd_ready_i)
        @(negedge core_clk_i);
    end
    @(negedge core_clk_i);
    cmd_valid_o = 1'b0;
    cmd_data_o  = ~cmd_data_o;
    while (n < 300 && (rsp.len() == 0 || rsp[rsp.len() - 1] != 8'h0a))
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (rsp.len() > 1 && rsp.substr(rsp.len() - 2, rsp.len() - 1) == "\r\n")
      r = rsp.substr(0, rsp.len() - 3);
    else
      r = {rsp, "#"};
  endtask
endmodule

// ==== spectral_control_command_set_test.sv ====
// Self-checking bench for the command decoder
`timescale 1ns/1ns
module spectral_control_command_set_test
  import spectral_cmd_pkg::*;
;
  localparam settings_t WR = {8'hff, 2'h3, 1'h1, 2'h3, 8'hff, 8'h07, 1'h0, 6'h36, 8'h33};
  logic       core_clk_i = 1'b0, rst_n_i = 1'b0, stall = 1'b0;
  logic       rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, sample_o, bank_o, burst_req_o;
  logic [7:0] rx_data_i, tx_data_o;
  settings_t  settings_o;
  int         failures, checks_done, bursts, samples;
  string      r;
  spectral_control_command_set #(.UNIT_CYC(2)) uut (
    .core_clk_i, .rst_n_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o,
    .tx_data_o, .tx_ready_i, .settings_o, .sample_o, .bank_o, .burst_req_o);
  spectral_host_model host (
    .core_clk_i, .cmd_ready_i(rx_ready_o), .rsp_valid_i(tx_valid_o),
    .rsp_data_i(tx_data_o), .stall_i(stall), .cmd_valid_o(rx_valid_i),
    .cmd_data_o(rx_data_i), .rsp_ready_o(tx_ready_i));
  always #10 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i)
  begin
    bursts  += (burst_req_o === 1'b1);
    samples += (sample_o === 1'b1);
  end
  task automatic check(input string what, input string seen, input string exp);
    checks_done++;
    if (seen != exp)
    begin
      failures++;
      $display("unexpected %s: expected %s seen %s", what, exp, seen);
    end
  endtask
  task automatic ok(input string s);
    host.send(s, "\r", r);
    check(s, r, "OK");
  endtask
  task automatic t_defaults();
    string nm [9] = '{"INTTIME", "GAIN", "INTRP", "TCSMD", "INTRVL", "BURST", "LED0",
      "LED1", "LEDC"};
    string rb [9] = '{"20OK", "1OK", "0OK", "2OK", "1OK", "0,0OK", "1OK", "0OK", "0x00OK"};
    check("reset", $sformatf("%h", settings_o), "14500801500");
    foreach (nm[i])
    begin
      host.send(nm[i], "\r", r);
      check(nm[i], r, rb[i]);
    end
    $display("t_defaults done");
  endtask
  task automatic t_write();
    string nm [11] = '{"INTTIME", "GAIN", "INTRP", "TCSMD", "INTRVL", "BURST", "BURST",
      "LED1", "LED0", "LED5", "LEDC"};
    string ag [11] = '{"0xff", "3", "1", "3", "255", "200,1", "7", "1", "0", "1", "0x33"};
    string rb [11] = '{"255", "3", "1", "3", "255", "200,1", "7,0", "1", "0", "1", "0x33"};
    foreach (nm[i])
    begin
      ok({nm[i], "=", ag[i]});
      host.send(nm[i], "\r", r);
      check(nm[i], r, {rb[i], "OK"});
    end
    check("store", $sformatf("%h", settings_o), $sformatf("%h", WR));
    $display("t_write done");
  endtask
  task automatic t_errors();
    string bad [10] = '{"INTTIME=0", "INTTIME=256", "GAIN=4", "TCSMD=4", "INTRVL=0",
      "LEDC=0x04", "BURST=5,2", "LED2=2", "FOO", "GAIN=1,1"};
    foreach (bad[i])
    begin
      host.send(bad[i], "\r", r);
      check(bad[i], r, "ERROR");
    end
    check("kept", $sformatf("%h", settings_o), $sformatf("%h", WR));
    $display("t_errors done");
  endtask
  task automatic t_terms();
    host.send("GAIN=2", "\n", r);
    check("lf", r, "OK");
    host.send("GAIN", "\r\n", r);
    check("crlf", r, "2OK");
    ok("");
    $display("t_terms done");
  endtask
  task automatic t_stall();
    stall = 1'b1;
    fork
      host.send("INTRVL", "\r", r);
      begin
        repeat (40) @(negedge core_clk_i);
        check("held", $sformatf("%b", rx_ready_o), "0");
        stall = 1'b0;
      end
    join
    check("slow", r, "255OK");
    $display("t_stall done");
  endtask
  task automatic t_burst();
    ok("INTRVL=1");
    ok("TCSMD=0");
    ok("BURST=0");
    bursts = 0;
    ok("BURST=3");
    ok("INTTIME=1");
    repeat (60) @(negedge core_clk_i);
    check("count", $sformatf("%0d", bursts), "3");
    ok("BURST=255");
    repeat (40) @(negedge core_clk_i);
    check("stream", $sformatf("%b", bursts > 15), "1");
    ok("INTTIME=255");
    ok("BURST=0");
    bursts = 0;
    ok("INTTIME=1");
    ok("TCSMD=1");
    repeat (60) @(negedge core_clk_i);
    check("stop", $sformatf("%0d", bursts), "0");
    ok("INTTIME=255");
    samples = 0;
    ok("TCSMD=3");
    repeat (1100) @(negedge core_clk_i);
    check("once", $sformatf("%0d", samples), "1");
    $display("t_burst done");
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_defaults();
    t_write();
    t_errors();
    t_terms();
    t_stall();
    t_burst();
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    wrap_up();
  end
endmodule
